// File: hw/mts_pkg.sv
/*
  Shared constants of the measurement trigger sequencer.
  Assumes a single 40 MHz clock domain.
*/
`default_nettype none
// Function
// - Continuous mode, not scanning: idle falls straight through to event detection.
// - One-shot mode: stay idle until the manual trigger key is pressed.
// - One-shot mode: return to idle after each measurement, need fresh key.
// - Shipped defaults select continuous; reset-command defaults select one-shot.
// - Scanning: idle at scan end holding last reading; halt request resumes.
// - Control-source stage blocks progress until the selected event is detected.
// - Immediate source: event detection satisfied at once.
// - External source: trigger-link input trigger satisfies detection.
// - External source: trigger key satisfies detection only in local mode.
// - External source: bus trigger command satisfies detection.
// - After each device action, pulse the meter-complete output.
// - Link line 1 is meter-complete output, line 2 external trigger input.
// - Interlock low ignores all input triggers; open or high accepts them. The code gates only the link and bus triggers, not the key.
package mts_pkg;
  localparam int  CLK_HZ          = 40000000;
  localparam int  DONE_PULSE_NS   = 1000;
  localparam int  DONE_PULSE_CYC  =
    (DONE_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [5:0] DONE_PULSE_LAST = 6'(DONE_PULSE_CYC - 1);
  localparam logic MODE_CONT_RST  = 1'h1;
  localparam logic SRC_IMM        = 1'h0;
  localparam logic SRC_EXT        = 1'h1;
  localparam logic SRC_RST        = 1'h0;
  typedef enum logic [1:0] {
    ST_IDLE, ST_DETECT, ST_ACTION, ST_SCAN_END
  } mts_state_type;
endpackage : mts_pkg
`default_nettype wire

// File: hw/mts_sync.sv
/*
  Two-stage synchroniser with rising-edge strobe.
  Assumes the input is asynchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'h0;
      sync_reg <= 1'h0;
      last_reg <= 1'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;
endmodule : mts_sync
`default_nettype wire

// File: hw/mts_top.sv
/*
  Front-panel trigger sequencer: idle, control source gate, device action
  handshake and meter-complete output pulse.
  Assumes bus trigger, key and halt inputs are one-cycle pulses from logic
  on MCLK_I; link and interlock pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_top (
  input  wire logic MCLK_I,
  input  wire logic RESETN_I,
  input  wire logic LINK_EXT_TRIG_I,
  input  wire logic INTERLOCK_I,
  input  wire logic TRIG_KEY_I,
  input  wire logic BUS_TRIG_I,
  input  wire logic REMOTE_I,
  input  wire logic SHIPPED_DEFAULTS_I,
  input  wire logic RST_DEFAULTS_I,
  input  wire logic EXTERNAL_SOURCE_SELECT_KEY_I,
  input  wire logic SCAN_ACTIVE_I,
  input  wire logic SCAN_LAST_I,
  input  wire logic HALT_I,
  input  wire logic ACTION_DONE_I,
  output logic      ACTION_START_O,
  output logic      METER_DONE_OUTPUT_O,
  output logic      CONT_MODE_O,
  output logic      SRC_EXT_O,
  output logic      IDLE_O,
  output logic      HOLD_READING_O
);
  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic ext_rise;
  logic ilk_level;

  // Line 2 of the link is the external trigger input
  mts_sync u_ext (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .async_i (LINK_EXT_TRIG_I),
    .level_o (),
    .rise_o  (ext_rise)
  );

  mts_sync u_ilk (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .async_i (INTERLOCK_I),
    .level_o (ilk_level),
    .rise_o  ()
  );

  logic key_ok;
  logic trig_in;
  assign key_ok  = TRIG_KEY_I & ~REMOTE_I;
  // Interlock only gates the link and bus inputs, not the local key
  assign trig_in = ilk_level & (ext_rise | BUS_TRIG_I);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  logic cont_reg;
  logic cont_next;
  logic src_reg;
  logic src_next;

  always_comb begin
    cont_next = cont_reg;
    src_next  = src_reg;
    if (SHIPPED_DEFAULTS_I) begin
      cont_next = 1'h1;
      src_next  = mts_pkg::SRC_IMM;
    end else if (RST_DEFAULTS_I) begin
      cont_next = 1'h0;
      src_next  = mts_pkg::SRC_IMM;
    end else if (EXTERNAL_SOURCE_SELECT_KEY_I) begin
      src_next  = ~src_reg;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cont_reg <= mts_pkg::MODE_CONT_RST;
      src_reg  <= mts_pkg::SRC_RST;
    end else begin
      cont_reg <= cont_next;
      src_reg  <= src_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mts_pkg::mts_state_type state_reg;
  mts_pkg::mts_state_type state_next;
  logic                   last_reg;
  logic                   last_next;
  logic                   event_ok;
  logic                   start;

  always_comb begin
    if (src_reg == mts_pkg::SRC_EXT) begin
      event_ok = trig_in | key_ok;
    end else begin
      event_ok = 1'h1;
    end
  end

  always_comb begin
    state_next = state_reg;
    last_next  = last_reg;
    start      = 1'h0;
    unique case (state_reg)
      mts_pkg::ST_IDLE: begin
        // In continuous mode idle is never lingered in
        if (cont_reg | SCAN_ACTIVE_I | key_ok) begin
          state_next = mts_pkg::ST_DETECT;
        end
      end
      mts_pkg::ST_DETECT: begin
        if (event_ok) begin
          state_next = mts_pkg::ST_ACTION;
          start      = 1'h1;
          last_next  = SCAN_ACTIVE_I & SCAN_LAST_I;
        end
      end
      mts_pkg::ST_ACTION: begin
        if (ACTION_DONE_I) begin
          if (last_reg) begin
            state_next = mts_pkg::ST_SCAN_END;
          end else if (!cont_reg && !SCAN_ACTIVE_I) begin
            state_next = mts_pkg::ST_IDLE;
          end else begin
            state_next = mts_pkg::ST_DETECT;
          end
        end
      end
      mts_pkg::ST_SCAN_END: begin
        if (HALT_I) begin
          state_next = mts_pkg::ST_IDLE;
          last_next  = 1'h0;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= mts_pkg::ST_IDLE;
      last_reg  <= 1'h0;
    end else begin
      state_reg <= state_next;
      last_reg  <= last_next;
    end
  end

  // ----------------------------------------------------------------
  // Meter-complete pulse on link line 1
  // ----------------------------------------------------------------
  logic [5:0] pcnt_reg;
  logic [5:0] pcnt_next;
  logic       done_reg;
  logic       done_next;
  logic       fire;

  assign fire = (state_reg == mts_pkg::ST_ACTION) & ACTION_DONE_I;

  always_comb begin
    pcnt_next = pcnt_reg;
    done_next = done_reg;
    if (fire) begin
      done_next = 1'h1;
      pcnt_next = mts_pkg::DONE_PULSE_LAST;
    end else if (pcnt_reg != 6'h00) begin
      pcnt_next = pcnt_reg - 6'h01;
    end else begin
      done_next = 1'h0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pcnt_reg <= 6'h00;
      done_reg <= 1'h0;
    end else begin
      pcnt_reg <= pcnt_next;
      done_reg <= done_next;
    end
  end

  assign ACTION_START_O      = start;
  assign METER_DONE_OUTPUT_O = done_reg;
  assign CONT_MODE_O         = cont_reg;
  assign SRC_EXT_O           = src_reg;
  assign IDLE_O              = (state_reg == mts_pkg::ST_IDLE) |
                               (state_reg == mts_pkg::ST_SCAN_END);
  assign HOLD_READING_O      = (state_reg == mts_pkg::ST_SCAN_END);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cont_idle_pass: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_IDLE && cont_reg) |=>
    state_reg == mts_pkg::ST_DETECT) else $error("idle not passed");
  a_oneshot_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_IDLE && !cont_reg && !SCAN_ACTIVE_I
     && !key_ok) |=> state_reg == mts_pkg::ST_IDLE)
    else $error("left idle without key");
  a_oneshot_ret: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (fire && !cont_reg && !SCAN_ACTIVE_I && !last_reg) |=>
    state_reg == mts_pkg::ST_IDLE) else $error("no return to idle");
  a_defaults_mode: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    SHIPPED_DEFAULTS_I |=> cont_reg) else $error("default mode");
  a_rst_mode: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (RST_DEFAULTS_I && !SHIPPED_DEFAULTS_I) |=> !cont_reg)
    else $error("reset mode");
  a_scan_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (HOLD_READING_O && !HALT_I) |=> HOLD_READING_O)
    else $error("scan end left");
  a_gate_block: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_DETECT && src_reg && !trig_in && !key_ok)
    |=> state_reg == mts_pkg::ST_DETECT) else $error("gate leak");
  a_imm_go: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_DETECT && !src_reg) |-> ACTION_START_O)
    else $error("immediate stalled");
  a_remote_key: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_DETECT && src_reg && REMOTE_I && !trig_in)
    |-> !ACTION_START_O) else $error("remote key");
  a_interlock: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (state_reg == mts_pkg::ST_DETECT && src_reg && !ilk_level && !key_ok)
    |-> !ACTION_START_O) else $error("interlock");
  a_done_pulse: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    fire |=> METER_DONE_OUTPUT_O) else $error("no done pulse");
  c_one_shot: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    !cont_reg && key_ok && state_reg == mts_pkg::ST_IDLE);
  c_ext_trig: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    src_reg && ext_rise && state_reg == mts_pkg::ST_DETECT);
  c_scan_end: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    HOLD_READING_O && HALT_I);
endmodule : mts_top
`default_nettype wire

// File: bench/mts_partner.sv
/*
  Far-side model: other link instruments and the bus controller.
  Assumes it is clocked by the device clock and steered by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_partner (
  input  wire logic clk_i,
  input  wire logic done_i,
  output logic      link_o,
  output logic      bus_o,
  output int        width_o
);
  int run = 0;

  initial begin
    link_o  = 1'h0;
    bus_o   = 1'h0;
    width_o = 0;
  end

  // ----------------------------------------
  // Line 1 watcher: width of the last pulse
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (done_i === 1'h1) begin
      run <= run + 1;
    end else if (run != 0) begin
      width_o <= run;
      run     <= 0;
    end
  end

  // Held several cycles so the device must edge detect it
  task automatic fire_link;
    repeat (5) @(posedge clk_i) link_o <= 1'h1;
    @(posedge clk_i) link_o <= 1'h0;
  endtask : fire_link

  task automatic fire_bus;
    @(posedge clk_i) bus_o <= 1'h1;
    @(posedge clk_i) bus_o <= 1'h0;
  endtask : fire_bus
endmodule : mts_partner
`default_nettype wire

// File: bench/tb_top.sv
/*
  Self-checking bench of the trigger sequencer.
  Assumes the partner model drives link line 2 and bus triggers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic rem; logic ilk; int ev; int exp;} mts_row_type;
  logic       clk   = 1'h0;
  logic       rst_n = 1'h0;
  logic       rem   = 1'h0;
  logic       ilk   = 1'h1;
  logic       scan  = 1'h0;
  logic       last  = 1'h0;
  logic       done  = 1'h0;
  logic [4:0] pls   = 5'h00;
  logic       start, mdone, cont, sext, idle, hold, link, bus;
  int         width, s0, starts = 0, mismatches = 0, samples_checked = 0;
  // Events: 1 key, 2 bus, 3 link, 0 none; exp is the start count
  mts_row_type rows [7] = '{
    '{1'h0, 1'h1, 1, 1},
    '{1'h1, 1'h1, 1, 0},
    '{1'h0, 1'h1, 2, 1},
    '{1'h0, 1'h0, 2, 0},
    '{1'h0, 1'h1, 3, 1},
    '{1'h0, 1'h0, 3, 0},
    '{1'h0, 1'h1, 0, 0}};

  always #12.5 clk = ~clk;

  mts_top dut (.MCLK_I(clk), .RESETN_I(rst_n), .LINK_EXT_TRIG_I(link),
    .INTERLOCK_I(ilk), .TRIG_KEY_I(pls[0]), .BUS_TRIG_I(bus),
    .REMOTE_I(rem), .SHIPPED_DEFAULTS_I(pls[1]), .RST_DEFAULTS_I(pls[2]),
    .EXTERNAL_SOURCE_SELECT_KEY_I(pls[3]), .SCAN_ACTIVE_I(scan),
    .SCAN_LAST_I(last), .HALT_I(pls[4]), .ACTION_DONE_I(done),
    .ACTION_START_O(start), .METER_DONE_OUTPUT_O(mdone),
    .CONT_MODE_O(cont), .SRC_EXT_O(sext), .IDLE_O(idle),
    .HOLD_READING_O(hold));

  mts_partner p (.clk_i(clk), .done_i(mdone), .link_o(link), .bus_o(bus),
    .width_o(width));

  // Device action finishes one cycle after each start
  always @(posedge clk) begin
    done <= (start === 1'h1);
    if (start === 1'h1) starts <= starts + 1;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic fire(input int b);
    @(posedge clk) pls[b] <= 1'h1;
    @(posedge clk) pls[b] <= 1'h0;
  endtask : fire

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    tick(6000);
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(10);
    chk("cont_rst", 1'h1, cont);
    chk("idle_rst", 1'h1, idle);
    chk("src_rst", 1'h0, sext);
    tick(2);
    rst_n <= 1'h1;
    fire(3);
    tick(4);
    chk("src_ext", 1'h1, sext);
    foreach (rows[i]) begin
      rem <= rows[i].rem;
      ilk <= rows[i].ilk;
      tick(4);
      s0 = starts;
      case (rows[i].ev)
        1: fire(0);
        2: p.fire_bus();
        3: p.fire_link();
        default: tick(1);
      endcase
      tick(8);
      chk("row_starts", rows[i].exp, starts - s0);
    end
    rem <= 1'h0;
    ilk <= 1'h1;
    fire(1);
    tick(4);
    chk("cont", 1'h1, cont);
    chk("src_imm", 1'h0, sext);
    s0 = starts;
    tick(20);
    chk("free_run", 1'h1, starts - s0 >= 9);
    scan <= 1'h1;
    last <= 1'h1;
    tick(6);
    chk("hold", 1'h1, hold);
    chk("scan_idle", 1'h1, idle);
    s0 = starts;
    tick(10);
    chk("scan_end_starts", 0, starts - s0);
    last <= 1'h0;
    fire(4);
    tick(10);
    chk("resume", 1'h1, starts - s0 >= 3);
    scan <= 1'h0;
    fire(2);
    tick(6);
    chk("oneshot", 1'h0, cont);
    s0 = starts;
    // Long enough for the retriggered done pulse to fall before the key
    tick(50);
    chk("idle_wait", 0, starts - s0);
    chk("idle", 1'h1, idle);
    fire(0);
    tick(60);
    chk("one_meas", 1, starts - s0);
    chk("idle_again", 1'h1, idle);
    chk("done_width", mts_pkg::DONE_PULSE_CYC, width);
    rst_n <= 1'h0;
    tick(2);
    chk("cont_rst2", 1'h1, cont);
    chk("idle_rst2", 1'h1, idle);
    chk("src_rst2", 1'h0, sext);
    rst_n <= 1'h1;
    s0 = starts;
    tick(11);
    chk("rst_run", 1'h1, starts - s0 >= 4);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
